// ### hdl/torque_homing.sv
// Profile torque and homing mode logic with its register port
`timescale 1ns/10ps
`include "torque_homing_params.svh"
module torque_homing #(
  parameter int MS_CYC = `MS_CYCLES
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire torque_homing_pkg::bus_req_t bus,
  output logic [31:0] rdata,
  input wire logic signed [15:0] torque_act,
  input wire logic [15:0] motor_cur,
  input wire logic speed_zero,
  input wire logic signed [31:0] pos_act,
  input wire logic lim_neg_pin,
  input wire logic lim_pos_pin,
  input wire logic home_pin,
  input wire logic index_pin,
  output logic signed [15:0] torque_dem,
  output logic speed_limit_en,
  output logic field_weak_en,
  output logic move_en,
  output logic move_dir,
  output logic move_slow,
  output logic zero_load,
  output logic signed [31:0] zero_value,
  output logic fault
);
  logic [7:0] mode_q;
  logic [15:0] ctrl_q, cfg_q, slope_q, win_q, win_ms_q, peak_ms_q;
  logic [15:0] blk_cur_q, blk_ms_q;
  logic signed [15:0] tgt_q, max_q, peak_q;
  logic signed [31:0] home_ofs_q, band_q, lim_pos_cap_q;
  logic signed [7:0] meth_q;
  logic [3:0] sync1_q, sync2_q;
  logic idx_prev_q, lim_prev_q, attained_q, fault_q;
  logic [31:0] ms_cnt_q;
  logic tick;
  logic [15:0] win_cnt_q, blk_cnt_q;
  logic signed [15:0] dem_q, cap, lim, tgt_clamp, ramp_tgt, step, diff;
  logic tq_mode, hm_mode, halt, start, closed_loop, submode, reached, over;
  logic [15:0] status;
  torque_homing_pkg::home_state_t st_q;
  torque_homing_pkg::home_kind_t kind;
  logic [7:0] m_abs;
  logic on_block, use_index, dir_pos, hit, lim_neg_s, lim_pos_s, home_s, idx_rise;
  logic signed [31:0] dpos;
  logic tol_exceed;
  logic st_q_next_done;

  // Pins cross into the clock domain through two flops each
  genvar g;
  for (g = 0; g < 4; g++)
  begin : g_sync
    always_ff @(posedge clk_sys)
    begin
      if (srst)
      begin
        sync1_q[g] <= 1'b0;
        sync2_q[g] <= 1'b0;
      end
      else
      begin
        sync1_q[g] <= (g == 0) ? lim_neg_pin : (g == 1) ? lim_pos_pin :
                      (g == 2) ? home_pin : index_pin;
        sync2_q[g] <= sync1_q[g];
      end
    end
  end
  assign lim_neg_s = sync2_q[0];
  assign lim_pos_s = sync2_q[1];
  assign home_s = sync2_q[2];

  // Field decode of the control and configuration words
  assign tq_mode = (mode_q == `MODE_TORQUE);
  assign hm_mode = (mode_q == `MODE_HOMING);
  assign halt = ctrl_q[`CTRL_HALT_BIT];
  assign start = ctrl_q[`CTRL_START_BIT];
  assign closed_loop = cfg_q[`CFG_CLOSED_LOOP_BIT];
  assign submode = cfg_q[`CFG_SUBMODE_BIT];

  // Register writes; a write of the fault-clear bit is a one-shot
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      mode_q <= 8'h00;
      ctrl_q <= 16'h0000;
      cfg_q <= 16'h0000;
      tgt_q <= 16'sh0000;
      max_q <= `RST_MAX_TQ;
      slope_q <= 16'h0000;
      win_q <= 16'h0000;
      win_ms_q <= 16'h0000;
      peak_q <= `RST_PEAK_TQ;
      peak_ms_q <= 16'h0000;
      home_ofs_q <= 32'sh0000_0000;
      meth_q <= 8'sh00;
      band_q <= 32'sh0000_0000;
      blk_cur_q <= 16'hffff;
      blk_ms_q <= 16'h0000;
    end
    else if (bus.wr)
    begin
      unique case (bus.addr)
        `OFS_MODE: mode_q <= bus.wdata[7:0];
        `OFS_CTRL: ctrl_q <= bus.wdata[15:0];
        `OFS_CFG: cfg_q <= bus.wdata[15:0];
        `OFS_TGT_TQ: tgt_q <= bus.wdata[15:0];
        `OFS_MAX_TQ: max_q <= bus.wdata[15:0];
        `OFS_SLOPE: slope_q <= bus.wdata[15:0];
        `OFS_TQ_WIN: win_q <= bus.wdata[15:0];
        `OFS_TQ_WIN_MS: win_ms_q <= bus.wdata[15:0];
        `OFS_PEAK_TQ: peak_q <= bus.wdata[15:0];
        `OFS_PEAK_MS: peak_ms_q <= bus.wdata[15:0];
        `OFS_HOME_OFS: home_ofs_q <= bus.wdata;
        `OFS_HOME_METH: meth_q <= bus.wdata[7:0];
        `OFS_TOL_BAND: band_q <= bus.wdata;
        `OFS_BLK_CUR: blk_cur_q <= bus.wdata[15:0];
        `OFS_BLK_MS: blk_ms_q <= bus.wdata[15:0];
        default: ;
      endcase
    end
  end

  // Read data stands one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      rdata <= 32'h0000_0000;
    else if (bus.rd)
    begin
      unique case (bus.addr)
        `OFS_MODE: rdata <= {24'h000000, mode_q};
        `OFS_CTRL: rdata <= {16'h0000, ctrl_q};
        `OFS_CFG: rdata <= {16'h0000, cfg_q};
        `OFS_TGT_TQ: rdata <= {{16{tgt_q[15]}}, tgt_q};
        `OFS_MAX_TQ: rdata <= {{16{max_q[15]}}, max_q};
        `OFS_SLOPE: rdata <= {16'h0000, slope_q};
        `OFS_TQ_WIN: rdata <= {16'h0000, win_q};
        `OFS_TQ_WIN_MS: rdata <= {16'h0000, win_ms_q};
        `OFS_PEAK_TQ: rdata <= {{16{peak_q[15]}}, peak_q};
        `OFS_PEAK_MS: rdata <= {16'h0000, peak_ms_q};
        `OFS_HOME_OFS: rdata <= home_ofs_q;
        `OFS_HOME_METH: rdata <= {{24{meth_q[7]}}, meth_q};
        `OFS_TOL_BAND: rdata <= band_q;
        `OFS_BLK_CUR: rdata <= {16'h0000, blk_cur_q};
        `OFS_BLK_MS: rdata <= {16'h0000, blk_ms_q};
        `OFS_STATUS: rdata <= {16'h0000, status};
        `OFS_TQ_DEM: rdata <= {{16{dem_q[15]}}, dem_q};
        default: rdata <= 32'h0000_0000;
      endcase
    end
  end

  // Millisecond tick paces the ramp, the window timer and the block hold
  always_ff @(posedge clk_sys)
  begin
    if (srst || tick)
      ms_cnt_q <= 32'h0000_0000;
    else
      ms_cnt_q <= ms_cnt_q + 32'h0000_0001;
  end
  assign tick = (ms_cnt_q == 32'(MS_CYC - 1));

  // Limits: all in thousandths of rated; peak only counts with a duration set
  always_comb
  begin
    cap = (peak_ms_q != 16'h0000) ? peak_q : `TQ_RATED;
    lim = (max_q < cap) ? max_q : cap;
    tgt_clamp = (tgt_q > lim) ? lim : (tgt_q < -lim) ? -lim : tgt_q;
    // Halt set ramps to zero, halt cleared ramps to the preset target
    ramp_tgt = (tq_mode && !halt) ? tgt_clamp : 16'sh0000;
    step = 16'(slope_q / `TQ_PER_SEC);
    if (step == 16'sh0000)
      step = 16'sh0001;
    diff = ramp_tgt - dem_q;
  end

  // Ramp generator moves the demand by the slope share of one millisecond
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      dem_q <= 16'sh0000;
    else if (tick)
    begin
      if (diff > step)
        dem_q <= dem_q + step;
      else if (diff < -step)
        dem_q <= dem_q - step;
      else
        dem_q <= ramp_tgt;
    end
  end
  assign torque_dem = dem_q;

  // Actual torque must stay in the window for the window time
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      win_cnt_q <= 16'h0000;
    else if (tick)
    begin
      if ((torque_act - dem_q <= $signed(win_q)) && (dem_q - torque_act <= $signed(win_q)))
        win_cnt_q <= (win_cnt_q == 16'hffff) ? win_cnt_q : win_cnt_q + 16'h0001;
      else
        win_cnt_q <= 16'h0000;
    end
  end
  assign reached = (dem_q == tgt_clamp) && (win_cnt_q >= win_ms_q);
  assign over = tgt_q > max_q;

  // Submode steers the outer velocity loop
  assign speed_limit_en = tq_mode && !submode;
  assign field_weak_en = tq_mode && !submode;

  // Homing method decode; negative codes swap the limit for a block
  always_comb
  begin
    m_abs = meth_q[7] ? 8'(-meth_q) : 8'(meth_q);
    on_block = meth_q[7];
    use_index = (m_abs >= 8'h01 && m_abs <= 8'h0e) || m_abs == 8'h21 || m_abs == 8'h22;
    dir_pos = m_abs[0] == 1'b0;
    if (m_abs == 8'h01 || m_abs == 8'h02 || m_abs == 8'h11 || m_abs == 8'h12)
      kind = torque_homing_pkg::K_LIMIT;
    else if ((m_abs >= 8'h03 && m_abs <= 8'h0e) || (m_abs >= 8'h13 && m_abs <= 8'h1e))
      kind = torque_homing_pkg::K_HOME;
    else if (m_abs == 8'h21 || m_abs == 8'h22)
      kind = torque_homing_pkg::K_INDEX;
    else if (m_abs == 8'h23 && !on_block)
      kind = torque_homing_pkg::K_HERE;
    else
      kind = torque_homing_pkg::K_BAD;
    hit = (kind == torque_homing_pkg::K_HOME) ? home_s :
          on_block ? (motor_cur > blk_cur_q) :
          dir_pos ? lim_pos_s : lim_neg_s;
  end
  assign idx_rise = sync2_q[3] && !idx_prev_q;

  // Tolerance band: position is captured as a limit switch is reached
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      lim_prev_q <= 1'b0;
      idx_prev_q <= 1'b0;
      lim_pos_cap_q <= 32'sh0000_0000;
    end
    else
    begin
      lim_prev_q <= lim_neg_s || lim_pos_s;
      idx_prev_q <= sync2_q[3];
      if ((lim_neg_s || lim_pos_s) && !lim_prev_q)
        lim_pos_cap_q <= pos_act;
    end
  end
  assign dpos = pos_act - lim_pos_cap_q;
  assign tol_exceed = lim_prev_q && (dpos > band_q || -dpos > band_q);

  // Fault drops move_en in homing, torque demand is not held; the exceed event wins over a clear
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      fault_q <= 1'b0;
    else if (tol_exceed)
      fault_q <= 1'b1;
    else if (bus.wr && bus.addr == `OFS_CTRL && bus.wdata[`CTRL_FAULT_CLR_BIT])
      fault_q <= 1'b0;
  end
  assign fault = fault_q;

  // Homing sequence runs only while the start bit stays set
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      st_q <= torque_homing_pkg::H_IDLE;
      blk_cnt_q <= 16'h0000;
      move_dir <= 1'b0;
    end
    else if (!hm_mode)
      st_q <= torque_homing_pkg::H_IDLE;
    else
    begin
      unique case (st_q)
        torque_homing_pkg::H_IDLE:
          if (start)
          begin
            move_dir <= dir_pos;
            if (kind == torque_homing_pkg::K_BAD || (on_block && !closed_loop))
              st_q <= torque_homing_pkg::H_ERR;
            else if (kind == torque_homing_pkg::K_HERE)
              st_q <= torque_homing_pkg::H_DONE;
            else if (kind == torque_homing_pkg::K_INDEX)
              st_q <= torque_homing_pkg::H_INDEX;
            else
              st_q <= torque_homing_pkg::H_SEARCH;
          end
        torque_homing_pkg::H_SEARCH:
          if (!start)
            st_q <= torque_homing_pkg::H_IDLE;
          else if (fault_q)
            st_q <= torque_homing_pkg::H_ERR;
          else if (hit && on_block)
          begin
            blk_cnt_q <= 16'h0000;
            st_q <= torque_homing_pkg::H_BLOCK;
          end
          else if (hit)
            st_q <= use_index ? torque_homing_pkg::H_INDEX : torque_homing_pkg::H_DONE;
          else if (kind == torque_homing_pkg::K_HOME && (lim_neg_s || lim_pos_s))
            move_dir <= lim_neg_s; // Reverse off a limit while hunting the home switch
        torque_homing_pkg::H_BLOCK:
          if (!start)
            st_q <= torque_homing_pkg::H_IDLE;
          // The first tick after entry is a partial millisecond, so one more tick is waited
          else if (blk_cnt_q >= blk_ms_q && tick)
            st_q <= use_index ? torque_homing_pkg::H_INDEX : torque_homing_pkg::H_DONE;
          else if (tick)
            blk_cnt_q <= blk_cnt_q + 16'h0001;
        torque_homing_pkg::H_INDEX:
          if (!start)
            st_q <= torque_homing_pkg::H_IDLE;
          else if (fault_q)
            st_q <= torque_homing_pkg::H_ERR;
          else if (idx_rise)
            st_q <= torque_homing_pkg::H_DONE;
        torque_homing_pkg::H_DONE, torque_homing_pkg::H_ERR:
          if (!start)
            st_q <= torque_homing_pkg::H_IDLE;
        default: st_q <= torque_homing_pkg::H_IDLE;
      endcase
    end
  end

  // Motion requests toward the drive's position loop
  assign move_en = hm_mode && !fault_q && (st_q == torque_homing_pkg::H_SEARCH ||
                   st_q == torque_homing_pkg::H_BLOCK || st_q == torque_homing_pkg::H_INDEX);
  assign move_slow = (st_q == torque_homing_pkg::H_INDEX);

  // Attained flag and the zero load pulse on completion
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      attained_q <= 1'b0;
      zero_load <= 1'b0;
      zero_value <= 32'sh0000_0000;
    end
    else
    begin
      zero_load <= 1'b0;
      if (hm_mode && st_q != torque_homing_pkg::H_DONE && st_q_next_done)
      begin
        attained_q <= 1'b1;
        zero_load <= 1'b1;
        zero_value <= home_ofs_q;
      end
      else if (st_q == torque_homing_pkg::H_SEARCH || st_q == torque_homing_pkg::H_ERR)
        attained_q <= 1'b0;
    end
  end

  // Mirrors every transition of the sequence into the done state
  assign st_q_next_done = start && (
    (st_q == torque_homing_pkg::H_IDLE && kind == torque_homing_pkg::K_HERE) ||
    (st_q == torque_homing_pkg::H_SEARCH && !fault_q && hit && !on_block && !use_index) ||
    (st_q == torque_homing_pkg::H_BLOCK && blk_cnt_q >= blk_ms_q && tick && !use_index) ||
    (st_q == torque_homing_pkg::H_INDEX && !fault_q && idx_rise));

  // Status word: mode decides what bits 10 to 13 mean
  always_comb
  begin
    status = 16'h0000;
    if (tq_mode)
    begin
      status[`ST_TGT_BIT] = halt ? speed_zero : reached;
      status[`ST_LIMIT_BIT] = over;
    end
    else if (hm_mode)
    begin
      status[`ST_ERR_BIT] = (st_q == torque_homing_pkg::H_ERR);
      status[`ST_ATT_BIT] = attained_q;
      status[`ST_TGT_BIT] = (st_q == torque_homing_pkg::H_IDLE) ||
        ((st_q == torque_homing_pkg::H_DONE || st_q == torque_homing_pkg::H_ERR) && speed_zero);
    end
  end

  // Checks on the behaviour above
  property p_limit_bit;
    @(posedge clk_sys) disable iff (srst) tq_mode |-> status[`ST_LIMIT_BIT] == (tgt_q > max_q);
  endproperty
  a_limit_bit: assert property (p_limit_bit) else $error("limit bit wrong");
  property p_dem_bound;
    @(posedge clk_sys) disable iff (srst) tick |=> (dem_q <= $past(lim) || dem_q <= $past(dem_q));
  endproperty
  a_dem_bound: assert property (p_dem_bound) else $error("demand above limit");
  property p_halt_ramp;
    @(posedge clk_sys) disable iff (srst)
      (tq_mode && halt && tick && dem_q > 16'sh0000) |=> dem_q < $past(dem_q);
  endproperty
  a_halt_ramp: assert property (p_halt_ramp) else $error("halt did not ramp down");
  property p_reached;
    @(posedge clk_sys) disable iff (srst)
      (tq_mode && !halt && status[`ST_TGT_BIT]) |-> win_cnt_q >= win_ms_q;
  endproperty
  a_reached: assert property (p_reached) else $error("reached too early");
  property p_run_clears;
    @(posedge clk_sys) disable iff (srst)
      (st_q == torque_homing_pkg::H_SEARCH) ##1 (st_q == torque_homing_pkg::H_SEARCH) |-> !attained_q;
  endproperty
  a_run_clears: assert property (p_run_clears) else $error("attained kept in run");
  property p_err_bits;
    @(posedge clk_sys) disable iff (srst)
      (hm_mode && st_q == torque_homing_pkg::H_ERR) ##1 (st_q == torque_homing_pkg::H_ERR)
      |-> status[`ST_ERR_BIT:`ST_ATT_BIT] == 2'b10;
  endproperty
  a_err_bits: assert property (p_err_bits) else $error("error pattern wrong");
  property p_done_load;
    @(posedge clk_sys) disable iff (srst)
      $rose(zero_load) |-> ##[0:1] (st_q == torque_homing_pkg::H_DONE && zero_value == home_ofs_q);
  endproperty
  a_done_load: assert property (p_done_load) else $error("offset not loaded");
  property p_block_closed;
    @(posedge clk_sys) disable iff (srst) st_q == torque_homing_pkg::H_BLOCK |-> closed_loop;
  endproperty
  a_block_closed: assert property (p_block_closed) else $error("block in open loop");
  property p_tol;
    @(posedge clk_sys) disable iff (srst) tol_exceed |=> fault && !move_en;
  endproperty
  a_tol: assert property (p_tol) else $error("band exceed not faulted");
  property p_stop;
    @(posedge clk_sys) disable iff (srst)
      (hm_mode && st_q == torque_homing_pkg::H_SEARCH && !start) |=> st_q == torque_homing_pkg::H_IDLE;
  endproperty
  a_stop: assert property (p_stop) else $error("homing kept without start");
  property p_submode;
    @(posedge clk_sys) disable iff (srst) (tq_mode && submode) |-> !speed_limit_en && !field_weak_en;
  endproperty
  a_submode: assert property (p_submode) else $error("extras in true torque");
endmodule

// ### include/torque_homing_params.svh
// Register offsets, field positions, reset values and timing counts
`ifndef TORQUE_HOMING_PARAMS_SVH
`define TORQUE_HOMING_PARAMS_SVH
`define OFS_MODE 8'h00
`define OFS_CTRL 8'h04
`define OFS_CFG 8'h08
`define OFS_TGT_TQ 8'h0c
`define OFS_MAX_TQ 8'h10
`define OFS_SLOPE 8'h14
`define OFS_TQ_WIN 8'h18
`define OFS_TQ_WIN_MS 8'h1c
`define OFS_PEAK_TQ 8'h20
`define OFS_PEAK_MS 8'h24
`define OFS_HOME_OFS 8'h28
`define OFS_HOME_METH 8'h2c
`define OFS_TOL_BAND 8'h30
`define OFS_BLK_CUR 8'h34
`define OFS_BLK_MS 8'h38
`define OFS_STATUS 8'h3c
`define OFS_TQ_DEM 8'h40
`define MODE_TORQUE 8'h04
`define MODE_HOMING 8'h06
`define CTRL_START_BIT 4
`define CTRL_FAULT_CLR_BIT 7
`define CTRL_HALT_BIT 8
`define CFG_CLOSED_LOOP_BIT 0
`define CFG_SUBMODE_BIT 5
`define ST_TGT_BIT 10
`define ST_LIMIT_BIT 11
`define ST_ATT_BIT 12
`define ST_ERR_BIT 13
`define TQ_RATED 16'sh03e8
`define TQ_PER_SEC 16'h03e8
`define RST_MAX_TQ 16'sh03e8
`define RST_PEAK_TQ 16'sh03e8
`define CLK_PERIOD_NS 10
`define MS_TIME_NS 1000000
`define MS_CYCLES (`MS_TIME_NS / `CLK_PERIOD_NS)
`endif

// ### include/torque_homing_pkg.sv
// Types shared by the torque and homing mode logic
package torque_homing_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } bus_req_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_SEARCH = 3'b001,
    H_BLOCK = 3'b010,
    H_INDEX = 3'b011,
    H_DONE = 3'b100,
    H_ERR = 3'b101
  } home_state_t;

  typedef enum logic [2:0] {
    K_LIMIT = 3'b000,
    K_HOME = 3'b001,
    K_INDEX = 3'b010,
    K_HERE = 3'b011,
    K_BAD = 3'b100
  } home_kind_t;
endpackage

// ### test/bus_master_model.sv
// Register bus master model that stands in for the fieldbus side
`timescale 1ns/10ps
module bus_master_model (
  input wire logic clk_sys,
  output torque_homing_pkg::bus_req_t bus,
  input wire logic [31:0] rdata
);
  initial
  begin
    bus = '0;
  end

  // One strobe at a time, held across the taking edge, then released
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    bus.wr <= 1'b0;
    bus.wdata <= ~d; // Released data toggles so a stale value is never read
  endtask

  // Read data stands from the cycle after the strobe until the next read
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~bus.wdata};
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
  endtask
endmodule

// ### test/torque_homing_tb.sv
// Self-checking bench for the torque and homing mode logic
`timescale 1ns/10ps
`include "torque_homing_params.svh"
module torque_homing_tb;
  localparam int MS = 10;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  torque_homing_pkg::bus_req_t bus;
  logic [31:0] rdata;
  logic signed [31:0] zero_value;
  logic signed [15:0] torque_act, torque_dem;
  logic signed [15:0] tq_off = 16'sh0064;
  logic [15:0] motor_cur = 16'h0000;
  logic speed_zero = 1'b0, lim_neg_pin = 1'b0, lim_pos_pin = 1'b0, index_pin = 1'b0;
  logic home_pin = 1'b0;
  logic signed [31:0] pos_act = 32'sh0;
  logic speed_limit_en, field_weak_en, move_en, move_dir, move_slow, zero_load, fault;
  int fails = 0;
  int samples_checked = 0;
  int n;

  // Plant: measured torque exceeds demand by a settable error
  assign torque_act = torque_dem + tq_off;
  always #5 clk_sys = ~clk_sys;

  bus_master_model u_bus_master_model (.clk_sys(clk_sys), .bus(bus), .rdata(rdata));

  // Switch pins and position come from the bench so every homing path can be steered
  torque_homing #(.MS_CYC(MS)) u_torque_homing (
    .clk_sys(clk_sys), .srst(srst), .bus(bus), .rdata(rdata), .torque_act(torque_act),
    .motor_cur(motor_cur), .speed_zero(speed_zero), .pos_act(pos_act),
    .lim_neg_pin(lim_neg_pin), .lim_pos_pin(lim_pos_pin), .home_pin(home_pin),
    .index_pin(index_pin), .torque_dem(torque_dem), .speed_limit_en(speed_limit_en),
    .field_weak_en(field_weak_en), .move_en(move_en), .move_dir(move_dir),
    .move_slow(move_slow), .zero_load(zero_load), .zero_value(zero_value), .fault(fault)
  );

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] d);
    u_bus_master_model.wr(a, d);
  endtask

  task automatic rq(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    u_bus_master_model.rd(a, d);
    check(name, d, exp);
  endtask

  // One status bit against its expected level
  task automatic rb(input string name, input int b, input logic e);
    logic [31:0] d;
    u_bus_master_model.rd(`OFS_STATUS, d);
    check(name, {31'h0, d[b]}, {31'h0, e});
  endtask

  // Homing state pattern, bits 13, 12, 10 in that order
  task automatic hs(input logic [2:0] exp);
    logic [31:0] d;
    u_bus_master_model.rd(`OFS_STATUS, d);
    check("home_state", {29'h0, d[13], d[12], d[10]}, {29'h0, exp});
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge clk_sys);
  endtask

  // Bounded wait for the zero pulse, sampled after each edge settles
  task automatic wait_zero(output int c);
    c = 0;
    while (c < 300)
    begin
      @(posedge clk_sys);
      #1;
      c++;
      if (zero_load === 1'b1) break;
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog sized well beyond the thousand or so cycles the tests take
  initial
  begin
    tick(30000);
    fails++;
    $display("ERROR watchdog expected finish seen hang");
    summarize();
  end

  initial
  begin
    tick(16);
    srst <= 1'b0;
    rq("max_tq", `OFS_MAX_TQ, 32'h000003e8);
    rq("peak_tq", `OFS_PEAK_TQ, 32'h000003e8);
    rq("blk_cur", `OFS_BLK_CUR, 32'h0000ffff);
    rq("unmapped", 8'h44, 32'h00000000);
    $display("test reset done");
    w(`OFS_MODE, 32'h4);
    w(`OFS_CFG, 32'h0);
    tick(2);
    check("speed_lim", {31'h0, speed_limit_en}, 32'h1);
    check("field_weak", {31'h0, field_weak_en}, 32'h1);
    w(`OFS_CFG, 32'h20);
    tick(2);
    check("speed_lim", {31'h0, speed_limit_en}, 32'h0);
    check("field_weak", {31'h0, field_weak_en}, 32'h0);
    w(`OFS_TQ_WIN, 32'h2);
    w(`OFS_TQ_WIN_MS, 32'h3);
    w(`OFS_SLOPE, 32'h3e8);
    w(`OFS_MAX_TQ, 32'h32);
    w(`OFS_TGT_TQ, 32'h64);
    w(`OFS_CTRL, 32'h0);
    rb("limit", 11, 1'b1);
    w(`OFS_TGT_TQ, 32'h5);
    rb("limit", 11, 1'b0);
    tick(100);
    rq("demand", `OFS_TQ_DEM, 32'h5);
    rb("reached", 10, 1'b0);
    tq_off <= 16'sh0000;
    tick(60);
    rb("reached", 10, 1'b1);
    w(`OFS_CTRL, 32'h100);
    tick(100);
    rq("demand", `OFS_TQ_DEM, 32'h0);
    rb("reached", 10, 1'b0);
    speed_zero <= 1'b1;
    tick(2);
    rb("reached", 10, 1'b1);
    w(`OFS_CTRL, 32'h0);
    w(`OFS_MAX_TQ, 32'h7d0);
    w(`OFS_PEAK_TQ, 32'h5dc);
    w(`OFS_SLOPE, 32'hfde8); // Slope register is 16 bits: 65 per millisecond
    w(`OFS_TGT_TQ, 32'h4b0);
    tick(300);
    rq("demand", `OFS_TQ_DEM, 32'h3e8);
    w(`OFS_PEAK_MS, 32'h5);
    tick(100);
    rq("demand", `OFS_TQ_DEM, 32'h4b0);
    $display("test torque done");
    w(`OFS_MODE, 32'h6);
    w(`OFS_HOME_OFS, 32'h1234);
    w(`OFS_HOME_METH, 32'h23);
    w(`OFS_CTRL, 32'h10);
    wait_zero(n);
    check("zero_load", {31'h0, zero_load}, 32'h1);
    check("zero_value", zero_value, 32'h1234);
    tick(2);
    hs(3'b011);
    w(`OFS_CTRL, 32'h0);
    w(`OFS_HOME_METH, 32'h1);
    w(`OFS_CTRL, 32'h10);
    tick(3);
    check("move_en", {31'h0, move_en}, 32'h1);
    check("move_dir", {31'h0, move_dir}, 32'h0);
    hs(3'b000);
    lim_neg_pin <= 1'b1;
    tick(6);
    lim_neg_pin <= 1'b0;
    tick(6);
    index_pin <= 1'b1;
    wait_zero(n);
    index_pin <= 1'b0;
    check("zero_load", {31'h0, zero_load}, 32'h1);
    w(`OFS_CTRL, 32'h0);
    w(`OFS_HOME_METH, 32'h2);
    w(`OFS_CTRL, 32'h10);
    tick(3);
    check("move_dir", {31'h0, move_dir}, 32'h1);
    w(`OFS_CTRL, 32'h0);
    tick(3);
    hs(3'b001);
    w(`OFS_HOME_METH, 32'h12);
    w(`OFS_CTRL, 32'h10);
    tick(3);
    lim_pos_pin <= 1'b1;
    wait_zero(n);
    lim_pos_pin <= 1'b0;
    check("zero_load", {31'h0, zero_load}, 32'h1);
    w(`OFS_CTRL, 32'h0);
    w(`OFS_HOME_METH, 32'h13);
    w(`OFS_CTRL, 32'h10);
    tick(3);
    home_pin <= 1'b1;
    wait_zero(n);
    home_pin <= 1'b0;
    check("zero_home", {31'h0, zero_load}, 32'h1);
    w(`OFS_CTRL, 32'h0);
    w(`OFS_CFG, 32'h0);
    w(`OFS_HOME_METH, 32'hff);
    w(`OFS_CTRL, 32'h10);
    tick(3);
    hs(3'b101);
    check("move_en", {31'h0, move_en}, 32'h0);
    w(`OFS_CTRL, 32'h0);
    w(`OFS_CFG, 32'h1);
    w(`OFS_HOME_METH, 32'hee);
    w(`OFS_BLK_CUR, 32'h64);
    w(`OFS_BLK_MS, 32'h2);
    w(`OFS_CTRL, 32'h10);
    tick(3);
    motor_cur <= 16'h00c8;
    wait_zero(n);
    check("zero_load", {31'h0, zero_load}, 32'h1);
    check("block_hold", {31'h0, n >= 2 * MS}, 32'h1);
    check("block_hold_max", {31'h0, n <= 3 * MS + 1}, 32'h1);
    tick(2);
    hs(3'b011);
    // Leaving the band after a limit faults and stops; a clear loses to the event
    w(`OFS_CTRL, 32'h0);
    w(`OFS_TOL_BAND, 32'h10);
    w(`OFS_HOME_METH, 32'h1);
    w(`OFS_CTRL, 32'h10);
    tick(3);
    lim_neg_pin <= 1'b1;
    tick(4);
    pos_act <= 32'sh20;
    speed_zero <= 1'b0;
    tick(3);
    check("fault", {31'h0, fault}, 32'h1);
    check("move_en", {31'h0, move_en}, 32'h0);
    hs(3'b100);
    w(`OFS_CTRL, 32'h90);
    tick(1);
    check("fault_kept", {31'h0, fault}, 32'h1);
    lim_neg_pin <= 1'b0;
    pos_act <= 32'sh0;
    tick(2);
    w(`OFS_CTRL, 32'h80);
    tick(1);
    check("fault_clr", {31'h0, fault}, 32'h0);
    $display("test homing done");
    summarize();
  end
endmodule
